/* rtci_pkg.sv */
// Purpose: shared constants and types of the rtc serial slave and its master
// Assumes: 100 MHz system clock, 80 ns link sampling clock in the device
// Notes: times are in ns, cycle counts derived from them
package rtci_pkg;
  localparam logic [6:0] DEV_ID = 7'h6F;
  localparam logic [7:0] REG_LAST = 8'h19;
  localparam int NUM_REGS = 26;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 80;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int POWERUP_NS = 1280;
  localparam int POWERUP_CYC = (POWERUP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_WORD, D_WDATA, D_ACK, D_RDATA, D_MACK, D_IGNORE
  } rtci_dstate_t;
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_BYTE, H_RSTART, H_STOP
  } rtci_hstate_t;
endpackage

/* rtci_if.sv */
// Purpose: two wire link between master and rtc slave
// Assumes: open drain data line with pull-up, master drives clock push-pull
// Notes: wire level of data is resolved here from both enables
`timescale 1ns/10ps
interface rtci_if;
  logic scl;
  logic h_sda_oe;
  logic h_sda_o;
  logic d_sda_oe;
  logic d_sda_o;
  logic sda;
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
  modport host (output scl, output h_sda_oe, output h_sda_o, input sda);
  modport dev (input scl, input sda, output d_sda_oe, output d_sda_o);
endinterface

/* rtci_dev.sv */
// Purpose: rtc serial slave giving byte access to the register array
// Assumes: link_clk_in oversamples the link well above the bus bit rate
// Notes: written bytes are reported on the system clock through a 2 entry buffer
// Behaviour
// R01: address byte after start carries identifier
// R02: low address bit selects read or write
// R03: acknowledge only on identifier match
// R04: word address follows, else internal pointer
// R05: pointer is zero after power-up
// R06: random read repeats same identifier
// R07: write is address, word, one data
// R08: standby after write until next start
// R09: random read uses repeated start sequence
// R10: keep sending while master acknowledges
// R11: master ends read with stop
// R12: read pointer loaded from word address
// R13: pointer advances per transmitted byte
// R14: pointer wraps from 19h to 00h
// R15: all bytes most significant bit first
// R16: start ignored during power-up
// R17: acknowledge each received write byte; data byte not acknowledged while previous write still in crossing
// R18: mismatch releases line, waits for start
`timescale 1ns/10ps
module rtci_dev
  import rtci_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic link_clk_in,
  rtci_if.dev link,
  output logic wr_valid_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  input wire logic wr_ready_in
);
  typedef logic [NUM_REGS-1:0][7:0] rtci_mem_t;

  typedef struct packed {
    rtci_dstate_t st;
    rtci_dstate_t nxt;
    logic scl1;
    logic scl2;
    logic sclp;
    logic sda1;
    logic sda2;
    logic sdap;
    logic ack1;
    logic ack2;
    logic oe;
    logic ev_tog;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] ev_addr;
    logic [7:0] ev_data;
    logic [4:0] pwr;
    rtci_mem_t mem;
  } rtci_link_t;

  typedef struct packed {
    logic t1;
    logic t2;
    logic seen;
    logic ackt;
    logic hv;
    logic [7:0] ha;
    logic [7:0] hd;
    logic sv;
    logic [7:0] sa;
    logic [7:0] sd;
  } rtci_sys_t;

  function automatic logic [7:0] rd_byte(input rtci_mem_t m, input logic [7:0] p);
    return (p <= REG_LAST) ? m[p[4:0]] : 8'h00;
  endfunction

  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    return (p >= REG_LAST) ? PTR_RESET : p + 8'h01; // see R14
  endfunction

  rtci_link_t l;
  rtci_link_t next_l;
  rtci_sys_t c;
  rtci_sys_t next_c;
  logic rs1;
  logic rs2;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic busy;

  // reset brought into the link domain
  always_ff @(posedge link_clk_in) begin
    rs1 <= resetn_in;
    rs2 <= rs1;
  end

  assign rise = l.scl2 & ~l.sclp;
  assign fall = ~l.scl2 & l.sclp;
  assign start = l.scl2 & l.sclp & l.sdap & ~l.sda2;
  assign stop = l.scl2 & l.sclp & ~l.sdap & l.sda2;
  assign busy = l.ev_tog != l.ack2;

  always_comb begin
    next_l = l;
    next_l.scl1 = link.scl;
    next_l.scl2 = l.scl1;
    next_l.sclp = l.scl2;
    next_l.sda1 = link.sda;
    next_l.sda2 = l.sda1;
    next_l.sdap = l.sda2;
    next_l.ack1 = c.ackt;
    next_l.ack2 = l.ack1;
    if (l.pwr != 5'h0) begin
      next_l.pwr = l.pwr - 5'h1;
    end
    if (stop) begin
      next_l.st = D_IDLE;
      next_l.oe = 1'b0;
    end else if (start && l.pwr == 5'h0) begin // see R16
      next_l.st = D_ADDR;
      next_l.bits = 4'h0;
      next_l.oe = 1'b0;
    end else begin
      unique case (l.st)
        D_ADDR, D_WORD, D_WDATA: begin
          if (rise) begin
            next_l.sh = {l.sh[6:0], l.sda2}; // see R15
            next_l.bits = l.bits + 4'h1;
          end else if (fall && l.bits == 4'h8) begin
            next_l.bits = 4'h0;
            if (l.st == D_ADDR) begin
              if (l.sh[7:1] == DEV_ID) begin // see R01
                next_l.oe = 1'b1; // see R03
                next_l.st = D_ACK;
                next_l.nxt = l.sh[0] ? D_RDATA : D_WORD; // see R02
              end else begin
                next_l.st = D_IGNORE; // see R18
              end
            end else if (l.st == D_WORD) begin
              next_l.ptr = l.sh; // see R04
              next_l.oe = 1'b1; // see R17
              next_l.st = D_ACK;
              next_l.nxt = D_WDATA;
            end else if (!busy) begin
              if (l.ptr <= REG_LAST) begin
                next_l.mem[l.ptr[4:0]] = l.sh; // see R07
              end
              next_l.ev_addr = l.ptr;
              next_l.ev_data = l.sh;
              next_l.ev_tog = ~l.ev_tog;
              next_l.ptr = ptr_inc(l.ptr);
              next_l.oe = 1'b1; // see R17
              next_l.st = D_ACK;
              next_l.nxt = D_IGNORE; // see R08
            end else begin
              next_l.st = D_IGNORE;
            end
          end
        end
        D_ACK: begin
          if (fall) begin
            next_l.bits = 4'h0;
            if (l.nxt == D_RDATA) begin
              next_l.sh = rd_byte(l.mem, l.ptr); // see R12
              next_l.oe = ~next_l.sh[7];
              next_l.bits = 4'h1;
            end else begin
              next_l.oe = 1'b0;
            end
            next_l.st = l.nxt;
          end
        end
        D_RDATA: begin
          if (fall) begin
            if (l.bits == 4'h8) begin
              next_l.oe = 1'b0;
              next_l.st = D_MACK;
              next_l.ptr = ptr_inc(l.ptr); // see R13
            end else begin
              next_l.oe = ~l.sh[6]; // see R15
              next_l.sh = {l.sh[6:0], 1'b0};
              next_l.bits = l.bits + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            if (!l.sda2) begin
              next_l.st = D_ACK; // see R10
              next_l.nxt = D_RDATA;
            end else begin
              next_l.st = D_IGNORE; // see R11
            end
          end
        end
        D_IDLE, D_IGNORE: begin
          next_l.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!rs2) begin
      l <= '0;
      l.st <= D_IDLE;
      l.nxt <= D_IDLE;
      l.scl1 <= 1'b1;
      l.scl2 <= 1'b1;
      l.sclp <= 1'b1;
      l.sda1 <= 1'b1;
      l.sda2 <= 1'b1;
      l.sdap <= 1'b1;
      l.ptr <= PTR_RESET; // see R05
      l.pwr <= 5'(POWERUP_CYC);
    end else begin
      l <= next_l;
    end
  end

  assign link.d_sda_oe = l.oe;
  assign link.d_sda_o = 1'b0;

  // write events arrive by toggle; words are stable until acknowledged
  always_comb begin
    next_c = c;
    next_c.t1 = l.ev_tog;
    next_c.t2 = c.t1;
    if (c.hv && wr_ready_in) begin
      next_c.hv = c.sv;
      next_c.ha = c.sa;
      next_c.hd = c.sd;
      next_c.sv = 1'b0;
    end
    if (c.t2 != c.seen && !c.sv) begin
      if (next_c.hv) begin
        next_c.sv = 1'b1;
        next_c.sa = l.ev_addr;
        next_c.sd = l.ev_data;
      end else begin
        next_c.hv = 1'b1;
        next_c.ha = l.ev_addr;
        next_c.hd = l.ev_data;
      end
      next_c.seen = c.t2;
      next_c.ackt = c.t2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign wr_valid_out = c.hv;
  assign wr_addr_out = c.ha;
  assign wr_data_out = c.hd;
endmodule // rtci_dev

/* rtci_host.sv */
// Purpose: bus master issuing single writes and random reads to the rtc
// Assumes: clock line made here by dividing clk_in into quarter phases
// Notes: read of n bytes acknowledges all but the last
`timescale 1ns/10ps
module rtci_host
  import rtci_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  rtci_if.host link,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_read_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic [7:0] cmd_len_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic done_out,
  output logic nack_out
);
  typedef struct packed {
    rtci_hstate_t st;
    logic [1:0] ph;
    logic [6:0] q;
    logic [3:0] bits;
    logic [1:0] step;
    logic [7:0] sh;
    logic rd;
    logic [7:0] len;
    logic [7:0] addr;
    logic [7:0] data;
    logic scl;
    logic oe;
    logic ackb;
    logic s1;
    logic s2;
    logic rdv;
    logic done;
    logic nack;
    logic ready;
  } rtci_hst_t;

  rtci_hst_t h;
  rtci_hst_t next_h;
  logic tick;
  logic rx;

  assign tick = h.q == 7'(QUARTER_CYC - 1);
  assign rx = h.rd && h.step == 2'd3;

  always_comb begin
    next_h = h;
    next_h.s1 = link.sda;
    next_h.s2 = h.s1;
    next_h.rdv = 1'b0;
    next_h.done = 1'b0;
    next_h.q = tick ? 7'h0 : h.q + 7'h1;
    unique case (h.st)
      H_IDLE: begin
        if (cmd_valid_in && h.ready) begin
          next_h.ready = 1'b0;
          next_h.nack = 1'b0;
          next_h.rd = cmd_read_in;
          next_h.addr = cmd_addr_in;
          next_h.data = cmd_data_in;
          next_h.len = cmd_len_in;
          next_h.step = 2'd0;
          next_h.sh = {DEV_ID, 1'b0}; // see R01
          next_h.ph = 2'd0;
          next_h.q = 7'h0;
          next_h.st = H_START;
        end
      end
      H_START: begin
        if (tick) begin
          if (h.ph == 2'd0) begin
            next_h.oe = 1'b1;
            next_h.ph = 2'd1;
          end else begin
            next_h.scl = 1'b0;
            next_h.ph = 2'd0;
            next_h.bits = 4'h0;
            next_h.st = H_BYTE;
          end
        end
      end
      H_BYTE: begin
        if (tick) begin
          next_h.ph = h.ph + 2'd1;
          unique case (h.ph)
            2'd0: begin
              if (h.bits == 4'h8) begin
                next_h.oe = rx && h.len > 8'h1; // see R10
              end else begin
                next_h.oe = rx ? 1'b0 : ~h.sh[7]; // see R15
              end
            end
            2'd1: next_h.scl = 1'b1;
            2'd2: begin
              if (h.bits == 4'h8) begin
                next_h.ackb = h.s2;
              end else if (rx) begin
                next_h.sh = {h.sh[6:0], h.s2};
              end
            end
            2'd3: begin
              next_h.scl = 1'b0;
              next_h.bits = h.bits + 4'h1;
              if (!rx && h.bits != 4'h8) begin
                next_h.sh = {h.sh[6:0], 1'b0};
              end
              if (h.bits == 4'h8) begin
                next_h.bits = 4'h0;
                next_h.oe = 1'b0;
                if (!rx && h.ackb) begin
                  next_h.nack = 1'b1;
                  next_h.st = H_STOP;
                end else begin
                  unique case (h.step)
                    2'd0: begin
                      next_h.step = 2'd1;
                      next_h.sh = h.addr;
                    end
                    2'd1: begin
                      next_h.step = 2'd2;
                      if (h.rd) begin
                        next_h.sh = {DEV_ID, 1'b1}; // see R06
                        next_h.st = H_RSTART; // see R09
                      end else begin
                        next_h.sh = h.data; // see R07
                      end
                    end
                    2'd2: begin
                      if (h.rd) begin
                        next_h.step = 2'd3;
                      end else begin
                        next_h.st = H_STOP;
                      end
                    end
                    2'd3: begin
                      next_h.rdv = 1'b1;
                      next_h.len = h.len - 8'h1;
                      if (h.len <= 8'h1) begin
                        next_h.st = H_STOP; // see R11
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      H_RSTART, H_STOP: begin
        if (tick) begin
          next_h.ph = h.ph + 2'd1;
          unique case (h.ph)
            2'd0: next_h.oe = h.st == H_STOP;
            2'd1: next_h.scl = 1'b1;
            2'd2: next_h.oe = h.st == H_RSTART;
            2'd3: begin
              if (h.st == H_RSTART) begin
                next_h.scl = 1'b0;
                next_h.st = H_BYTE;
              end else begin
                next_h.done = 1'b1;
                next_h.ready = 1'b1;
                next_h.st = H_IDLE;
              end
            end
          endcase
        end
      end
      default: begin
        next_h.st = H_IDLE;
        next_h.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      h <= '0;
      h.st <= H_IDLE;
      h.scl <= 1'b1;
      h.s1 <= 1'b1;
      h.s2 <= 1'b1;
      h.ready <= 1'b1;
    end else begin
      h <= next_h;
    end
  end

  assign link.scl = h.scl;
  assign link.h_sda_oe = h.oe;
  assign link.h_sda_o = 1'b0;
  assign cmd_ready_out = h.ready;
  assign rd_valid_out = h.rdv;
  assign rd_data_out = h.sh;
  assign done_out = h.done;
  assign nack_out = h.nack;
endmodule // rtci_host

/* rtci_sva.sv */
// Purpose: checks on the serial link between the rtc master and slave
// Assumes: both link ends are design code, clk_in samples the link
// Notes: bit counter restarts at each start; pu counts cycles since reset
`timescale 1ns/10ps
module rtci_sva
  import rtci_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic h_sda_o,
  input wire logic d_sda_oe,
  input wire logic d_sda_o
);
  logic scl_q;
  logic sda_q;
  logic [7:0] cnt;
  logic [7:0] pu;
  logic [7:0] sh;
  logic rise;
  logic start;
  logic live;
  logic early;
  logic id_slot;
  logic word_slot;
  assign rise = scl & ~scl_q;
  assign start = scl & sda_q & ~sda;
  // ack slots of frames whose start came after the slave's power-up window
  assign id_slot = rise && cnt == 8'd8 && live;
  assign word_slot = rise && cnt == 8'd17 && live;
  always_ff @(posedge clk_in) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!resetn_in) begin
      cnt <= 8'h00;
      pu <= 8'h00;
      sh <= 8'h00;
      live <= 1'b0;
      early <= 1'b0;
    end else begin
      if (pu != 8'hFF) pu <= pu + 8'h01;
      if (start) begin
        live <= (pu == 8'hFF);
        early <= (pu < 8'd120);
      end
      if (start) cnt <= 8'h00;
      else if (rise && cnt != 8'hFF) cnt <= cnt + 8'h01;
      if (rise && cnt < 8'h08) sh <= {sh[6:0], sda};
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  start_hold_a: assert property (s_start |-> scl [*8])
    else $error("clock not held high after start");
  stop_free_a: assert property (s_stop |-> !d_sda_oe)
    else $error("slave still pulls data at stop");
  dev_edge_a: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("slave data changed while clock high");
  clk_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  open_drain_a: assert property (d_sda_oe |-> !d_sda_o && !h_sda_o)
    else $error("data line driven high");
  powerup_quiet_a: assert property (pu < 8'd120 |-> !d_sda_oe)
    else $error("slave answered during power-up");
  id_ack_a: assert property (id_slot && sh[7:1] == DEV_ID |-> !sda)
    else $error("matching identifier not acknowledged");
  powerup_ignore_a: assert property (rise && cnt == 8'd8 && early |-> sda)
    else $error("start during power-up was answered");
  id_nack_a: assert property (rise && cnt == 8'd8 && sh[7:1] != DEV_ID |-> sda)
    else $error("foreign identifier acknowledged");
  word_ack_a: assert property (word_slot && sh == {DEV_ID, 1'b0} |-> !sda)
    else $error("word address not acknowledged");
endmodule // rtci_sva

/* tb_top.sv */
// Purpose: self-checking bench joining the rtc master and slave
// Assumes: reset held long enough for the slave's link-side synchroniser
// Notes: user write port is stalled to check the two entry buffer
`timescale 1ns/10ps
module tb_top
  import rtci_pkg::*;
;
  logic clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic resetn_in = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic wr_ready = 1'b0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic cmd_ready, rd_valid, done, nack, wr_valid;
  logic [7:0] rd_data, wr_addr, wr_data;
  logic [7:0] got[$];
  int n_fail = 0;
  int checked = 0;
  rtci_if link_if();
  rtci_host rtci_host_i(.clk_in(clk_in), .resetn_in(resetn_in), .link(link_if.host),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read),
    .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .cmd_len_in(cmd_len),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .done_out(done), .nack_out(nack));
  rtci_dev rtci_dev_i(.clk_in(clk_in), .resetn_in(resetn_in), .link_clk_in(link_clk),
    .link(link_if.dev), .wr_valid_out(wr_valid), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data), .wr_ready_in(wr_ready));
  rtci_sva rtci_sva_i(.clk_in(clk_in), .resetn_in(resetn_in), .scl(link_if.scl),
    .sda(link_if.sda), .h_sda_o(link_if.h_sda_o), .d_sda_oe(link_if.d_sda_oe),
    .d_sda_o(link_if.d_sda_o));
  always #5 clk_in = ~clk_in;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task do_reset;
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (40) @(posedge clk_in);
    resetn_in <= 1'b1;
  endtask
  // one command, waits for acceptance and done, collects read bytes
  task cmd(input logic rd, input logic [7:0] a, input logic [7:0] d, input logic [7:0] l);
    int i;
    got = {};
    @(posedge clk_in);
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_len <= l;
    cmd_valid <= 1'b1;
    i = 0;
    #1;
    // ready seen here is what the next edge samples
    while (cmd_ready !== 1'b1 && i < 50) begin
      @(posedge clk_in);
      #1;
      i++;
    end
    if (i >= 50) begin
      n_fail++;
      $display("FAIL cmd_ready expected 1 seen %b", cmd_ready);
      end_sim;
    end
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    i = 0;
    do begin
      @(posedge clk_in);
      #1;
      if (rd_valid === 1'b1) got.push_back(rd_data);
      i++;
    end while (done !== 1'b1 && i < 40000);
    if (i >= 40000) begin
      n_fail++;
      $display("FAIL done expected 1 seen %b", done);
      end_sim;
    end
  endtask
  task take(input logic [7:0] a, input logic [7:0] d);
    check("wr_valid", wr_valid, 8'h01);
    check("wr_addr", wr_addr, a);
    check("wr_data", wr_data, d);
    @(posedge clk_in);
    wr_ready <= 1'b1;
    @(posedge clk_in);
    wr_ready <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task t_write;
    cmd(1'b0, 8'h19, 8'h7E, 8'h01);
    check("nack", nack, 8'h00);
    check("scl idle", link_if.scl, 8'h01);
    check("sda idle", link_if.sda, 8'h01);
    take(8'h19, 8'h7E);
    cmd(1'b0, 8'h00, 8'hA5, 8'h01);
    take(8'h00, 8'hA5);
    $display("test write finished");
  endtask
  task t_buffer;
    cmd(1'b0, 8'h01, 8'h3C, 8'h01);
    cmd(1'b0, 8'h02, 8'hC3, 8'h01);
    check("nack", nack, 8'h00);
    // third word waits in the crossing while both entries are full
    cmd(1'b0, 8'h03, 8'h99, 8'h01);
    check("nack third", nack, 8'h00);
    cmd(1'b0, 8'h04, 8'h66, 8'h01);
    check("nack full", nack, 8'h01);
    take(8'h01, 8'h3C);
    take(8'h02, 8'hC3);
    take(8'h03, 8'h99);
    check("wr_valid empty", wr_valid, 8'h00);
    $display("test buffer finished");
  endtask
  task t_read;
    cmd(1'b1, 8'h19, 8'h00, 8'h03);
    check("rd count", 8'(got.size()), 8'h03);
    check("rd 19h", got[0], 8'h7E);
    check("rd wrap 00h", got[1], 8'hA5);
    check("rd 01h", got[2], 8'h3C);
    check("nack", nack, 8'h00);
    check("rd same id", nack, 8'h00);
    check("rd sda idle", link_if.sda, 8'h01);
    $display("test read finished");
  endtask
  task t_powerup;
    do_reset;
    cmd(1'b0, 8'h03, 8'h55, 8'h01);
    check("nack powerup", nack, 8'h01);
    check("wr_valid powerup", wr_valid, 8'h00);
    $display("test powerup finished");
  endtask
  initial begin
    do_reset;
    repeat (300) @(posedge clk_in);
    t_write;
    t_buffer;
    t_read;
    t_powerup;
    end_sim;
  end
endmodule // tb_top
